//--- logic/afcs_pkg.sv
// Constants for the front-end configuration shifter: register map, bit map, reset pattern.
// Assumes a 32-bit APB master with one aligned word per register.
`default_nettype none
package afcs_pkg;
   localparam int AFCS_SR_W = 56;
   // Register indices; the byte address is four times the index
   localparam logic [9:0] AFCS_IDX_STATUS = 10'h003;
   localparam logic [9:0] AFCS_IDX_SERIAL = 10'h005;
   localparam logic [9:0] AFCS_IDX_STROBE = 10'h00b;
   localparam logic [7:0] AFCS_STROBE_CODE = 8'h04;
   // Field positions in the shift register and latch
   localparam int AFCS_B_CH1_TERM = 6;
   localparam int AFCS_B_CH1_SE = 7;
   localparam int AFCS_B_CH1_LPF = 9;
   localparam int AFCS_B_CH1_ROUTE = 10;
   localparam int AFCS_B_CH2_TERM = 11;
   localparam int AFCS_B_CH2_SE = 12;
   localparam int AFCS_B_CH2_LPF = 14;
   localparam int AFCS_B_CH2_ROUTE = 15;
   localparam int AFCS_B_CH1_IN20 = 34;
   localparam int AFCS_B_CH1_POST = 35;
   localparam int AFCS_B_CH1_DIFF = 36;
   localparam int AFCS_B_CH1_INT6 = 37;
   localparam int AFCS_B_CH1_INT14 = 38;
   localparam int AFCS_B_CH2_IN20 = 42;
   localparam int AFCS_B_CH2_POST = 43;
   localparam int AFCS_B_CH2_DIFF = 44;
   localparam int AFCS_B_CH2_INT6 = 45;
   localparam int AFCS_B_CH2_INT14 = 46;
   // Inputs enabled, 50 ohm, filter out, attenuators bypassed and removed
   localparam logic [55:0] AFCS_RESET_PATTERN = 56'h006c6c00001080;
endpackage
`default_nettype wire

//--- logic/afcs_shifter.sv
// Front-end configuration shifter: 56-bit circular shift register, copy latch, APB slave.
// Assumes an APB master on pclk; latch outputs drive front-end relays directly.
// Notes on behaviour
// - Status read returns shift register bit 55
// - Serial write inserts bit 0, shifts all
// - Fifty-six write-backs of bit 55 restore every bit's position
// - Strobe write of 4 copies into latch
// - Bits 7, 12 enable single-ended inputs
// - Bits 36, 44 high disable differential inputs
// - Reset leaves all inputs enabled
// - Bits 6, 11 select 75 ohm termination
// - Bits 9, 14 insert lowpass filter
// - Bits 10, 15 route through attenuators
// - Bits 34, 42 low insert input 20 dB
// - Bits 35, 43 low insert post 20 dB
// - Bits 37, 45 low insert 6 dB
// - Bits 38, 46 low insert 14 dB
//
// The APB interface to the registers is this design's own decision.
`default_nettype none
module afcs_shifter
   import afcs_pkg::*;
#(
   parameter int ADDR_W = 12
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic ch1_single_input_en,
   output logic ch2_single_input_en,
   output logic ch1_diff_input_off,
   output logic ch2_diff_input_off,
   output logic ch1_termination_sel,
   output logic ch2_termination_sel,
   output logic ch1_lowpass_in,
   output logic ch2_lowpass_in,
   output logic ch1_atten_route,
   output logic ch2_atten_route,
   output logic ch1_input_20db_stage_off,
   output logic ch2_input_20db_stage_off,
   output logic ch1_post_stage_off,
   output logic ch2_post_stage_off,
   output logic ch1_internal_stage_off,
   output logic ch2_internal_stage_off,
   output logic ch1_internal14_stage_off,
   output logic ch2_internal14_stage_off
);

   typedef struct packed {
      logic [AFCS_SR_W-1:0] sr;
      logic [AFCS_SR_W-1:0] latch;
      logic [31:0] rdata;
      logic ready;
      logic err;
   } afcs_state_type;

   afcs_state_type st_r;
   afcs_state_type st_nxt;

   logic [9:0] idx;
   logic aligned;
   logic is_status;
   logic is_serial;
   logic is_strobe;
   logic hit;
   logic setup;
   logic take;
   logic wr_take;
   logic copy_take;

   assign idx = paddr[11:2];
   assign aligned = (paddr[1:0] == 2'b00) && ((paddr >> 12) == '0);
   assign is_status = aligned && (idx == AFCS_IDX_STATUS);
   assign is_serial = aligned && (idx == AFCS_IDX_SERIAL);
   assign is_strobe = aligned && (idx == AFCS_IDX_STROBE);
   assign hit = is_status || is_serial || is_strobe;
   assign setup = psel && !penable;
   assign take = psel && penable && st_r.ready;
   // Only lane 0 carries register data; a write with lane 0 off is a no-op
   assign wr_take = take && pwrite && pstrb[0];
   assign copy_take = wr_take && is_strobe && (pwdata[7:0] == AFCS_STROBE_CODE);

   always_comb begin
      st_nxt = st_r;
      st_nxt.ready = 1'b0;
      if (setup) begin
         // Answer decided in setup so the access phase completes with no wait
         st_nxt.ready = 1'b1;
         st_nxt.err = !hit;
         st_nxt.rdata = 32'h00000000;
         if (is_status && !pwrite) begin
            st_nxt.rdata = {31'h00000000, st_r.sr[AFCS_SR_W-1]};
         end
      end
      if (wr_take && is_serial) begin
         st_nxt.sr = {st_r.sr[AFCS_SR_W-2:0], pwdata[0]};
      end
      // Any other value in the low byte is ignored so stray writes cannot move relays
      if (copy_take) begin
         st_nxt.latch = st_r.sr;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_r.sr <= AFCS_RESET_PATTERN;
         st_r.latch <= AFCS_RESET_PATTERN;
         st_r.rdata <= 32'h00000000;
         st_r.ready <= 1'b0;
         st_r.err <= 1'b0;
      end else begin
         st_r <= st_nxt;
      end
   end

   assign prdata = st_r.rdata;
   assign pready = st_r.ready;
   assign pslverr = st_r.err;
   assign ch1_single_input_en = st_r.latch[AFCS_B_CH1_SE];
   assign ch2_single_input_en = st_r.latch[AFCS_B_CH2_SE];
   assign ch1_diff_input_off = st_r.latch[AFCS_B_CH1_DIFF];
   assign ch2_diff_input_off = st_r.latch[AFCS_B_CH2_DIFF];
   assign ch1_termination_sel = st_r.latch[AFCS_B_CH1_TERM];
   assign ch2_termination_sel = st_r.latch[AFCS_B_CH2_TERM];
   assign ch1_lowpass_in = st_r.latch[AFCS_B_CH1_LPF];
   assign ch2_lowpass_in = st_r.latch[AFCS_B_CH2_LPF];
   assign ch1_atten_route = st_r.latch[AFCS_B_CH1_ROUTE];
   assign ch2_atten_route = st_r.latch[AFCS_B_CH2_ROUTE];
   assign ch1_input_20db_stage_off = st_r.latch[AFCS_B_CH1_IN20];
   assign ch2_input_20db_stage_off = st_r.latch[AFCS_B_CH2_IN20];
   assign ch1_post_stage_off = st_r.latch[AFCS_B_CH1_POST];
   assign ch2_post_stage_off = st_r.latch[AFCS_B_CH2_POST];
   assign ch1_internal_stage_off = st_r.latch[AFCS_B_CH1_INT6];
   assign ch2_internal_stage_off = st_r.latch[AFCS_B_CH2_INT6];
   assign ch1_internal14_stage_off = st_r.latch[AFCS_B_CH1_INT14];
   assign ch2_internal14_stage_off = st_r.latch[AFCS_B_CH2_INT14];

   sequence s_setup;
      psel && !penable;
   endsequence

   sequence s_access;
      psel && penable && pready;
   endsequence

   sequence s_status_access;
      psel && penable && pready && !pwrite && is_status;
   endsequence

   sequence s_copy;
      copy_take;
   endsequence

   // Helper: counts serial writes since the last strobe write of any value, saturating
   logic [6:0] shift_cnt;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         shift_cnt <= 7'h00;
      end else if (wr_take && is_strobe) begin
         shift_cnt <= 7'h00;
      end else if (wr_take && is_serial && shift_cnt != 7'h7f) begin
         shift_cnt <= shift_cnt + 7'h01;
      end
   end

   a_status_read_bit: assert property (@(posedge pclk) disable iff (!presetn)
      s_setup ##1 s_status_access
      |-> (prdata == {31'h00000000, $past(st_r.sr[AFCS_SR_W-1])}))
      else $error("status read did not return bit 55");

   a_shift_insert: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_take && is_serial) |=>
      (st_r.sr == {$past(st_r.sr[AFCS_SR_W-2:0]), $past(pwdata[0])}))
      else $error("serial write did not shift in at bit 0");

   a_rotate_restore: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_take && is_serial && pwdata[0] == st_r.sr[AFCS_SR_W-1]) |=>
      (st_r.sr == {$past(st_r.sr[AFCS_SR_W-2:0]), $past(st_r.sr[AFCS_SR_W-1])}))
      else $error("write-back of bit 55 did not rotate the register");

   a_latch_copy: assert property (@(posedge pclk) disable iff (!presetn)
      s_copy |=>
      (st_r.latch == $past(st_r.sr)) ##1 $stable(st_r.latch))
      else $error("strobe of 4 did not copy the shift register");

   a_latch_hold: assert property (@(posedge pclk) disable iff (!presetn)
      !copy_take |=> $stable(st_r.latch))
      else $error("latch changed without a strobe of 4");

   a_read_no_shift: assert property (@(posedge pclk) disable iff (!presetn)
      (take && !pwrite) |=> $stable(st_r.sr))
      else $error("read altered the shift register");

   a_one_wait_answer: assert property (@(posedge pclk) disable iff (!presetn)
      s_setup |=> pready ##1 !pready)
      else $error("access phase not answered after one cycle");

   a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
      (s_setup and !hit) |=> (pready && pslverr))
      else $error("unmapped address not flagged");

   a_shift_count: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_take && is_serial && shift_cnt == 7'(AFCS_SR_W - 1)) |=>
      (shift_cnt == 7'(AFCS_SR_W)) && (st_r.sr[AFCS_SR_W-1] == $past(st_r.sr[AFCS_SR_W-2])))
      else $error("shift count or bit advance wrong at the 56th write");

   a_reset_inputs_on: assert property (@(posedge pclk)
      $rose(presetn) |-> (ch1_single_input_en && ch2_single_input_en
         && !ch1_diff_input_off && !ch2_diff_input_off && !ch1_lowpass_in))
      else $error("reset did not leave the inputs enabled");

   // Copy path: each front-end output takes its shift register bit at the strobe
   a_se_input_map: assert property (@(posedge pclk) disable iff (!presetn)
      s_copy |=> (ch1_single_input_en == $past(st_r.sr[AFCS_B_CH1_SE]))
      && (ch2_single_input_en == $past(st_r.sr[AFCS_B_CH2_SE])))
      else $error("single-ended enables not copied from the shift register");

   a_diff_input_map: assert property (@(posedge pclk) disable iff (!presetn)
      s_copy |=> (ch1_diff_input_off == $past(st_r.sr[AFCS_B_CH1_DIFF]))
      && (ch2_diff_input_off == $past(st_r.sr[AFCS_B_CH2_DIFF])))
      else $error("differential disables not copied from the shift register");

   a_term_sel_map: assert property (@(posedge pclk) disable iff (!presetn)
      s_copy |=> (ch1_termination_sel == $past(st_r.sr[AFCS_B_CH1_TERM]))
      && (ch2_termination_sel == $past(st_r.sr[AFCS_B_CH2_TERM])))
      else $error("termination selects not copied from the shift register");

   a_lowpass_map: assert property (@(posedge pclk) disable iff (!presetn)
      s_copy |=> (ch1_lowpass_in == $past(st_r.sr[AFCS_B_CH1_LPF]))
      && (ch2_lowpass_in == $past(st_r.sr[AFCS_B_CH2_LPF])))
      else $error("filter selects not copied from the shift register");

   a_route_map: assert property (@(posedge pclk) disable iff (!presetn)
      s_copy |=> (ch1_atten_route == $past(st_r.sr[AFCS_B_CH1_ROUTE]))
      && (ch2_atten_route == $past(st_r.sr[AFCS_B_CH2_ROUTE])))
      else $error("attenuator routes not copied from the shift register");

   a_input_stage_map: assert property (@(posedge pclk) disable iff (!presetn)
      s_copy |=> (ch1_input_20db_stage_off == $past(st_r.sr[AFCS_B_CH1_IN20]))
      && (ch2_input_20db_stage_off == $past(st_r.sr[AFCS_B_CH2_IN20])))
      else $error("input 20 dB stages not copied from the shift register");

   a_post_stage_map: assert property (@(posedge pclk) disable iff (!presetn)
      s_copy |=> (ch1_post_stage_off == $past(st_r.sr[AFCS_B_CH1_POST]))
      && (ch2_post_stage_off == $past(st_r.sr[AFCS_B_CH2_POST])))
      else $error("post 20 dB stages not copied from the shift register");

   a_int6_stage_map: assert property (@(posedge pclk) disable iff (!presetn)
      s_copy |=> (ch1_internal_stage_off == $past(st_r.sr[AFCS_B_CH1_INT6]))
      && (ch2_internal_stage_off == $past(st_r.sr[AFCS_B_CH2_INT6])))
      else $error("6 dB stages not copied from the shift register");

   a_int14_stage_map: assert property (@(posedge pclk) disable iff (!presetn)
      s_copy |=> (ch1_internal14_stage_off == $past(st_r.sr[AFCS_B_CH1_INT14]))
      && (ch2_internal14_stage_off == $past(st_r.sr[AFCS_B_CH2_INT14])))
      else $error("14 dB stages not copied from the shift register");

   // Relays must not move between strobes, whatever the bus does
   a_outputs_hold: assert property (@(posedge pclk) disable iff (!presetn)
      !copy_take |=> $stable({ch1_single_input_en, ch2_single_input_en, ch1_diff_input_off,
         ch2_diff_input_off, ch1_termination_sel, ch2_termination_sel, ch1_lowpass_in,
         ch2_lowpass_in, ch1_atten_route, ch2_atten_route, ch1_input_20db_stage_off,
         ch2_input_20db_stage_off, ch1_post_stage_off, ch2_post_stage_off,
         ch1_internal_stage_off, ch2_internal_stage_off, ch1_internal14_stage_off,
         ch2_internal14_stage_off}))
      else $error("front-end outputs moved without a strobe of 4");

   a_sr_hold: assert property (@(posedge pclk) disable iff (!presetn)
      !(wr_take && is_serial) |=> $stable(st_r.sr))
      else $error("shift register moved without a serial write");

   // A wrong code must not copy, or a stray write would move relays
   a_strobe_ignore: assert property (@(posedge pclk) disable iff (!presetn)
      (wr_take && is_strobe && (pwdata[7:0] != AFCS_STROBE_CODE)) |=> $stable(st_r.latch))
      else $error("strobe of another value changed the latch");

   a_lane_off_ignored: assert property (@(posedge pclk) disable iff (!presetn)
      (take && pwrite && !pstrb[0]) |=> ($stable(st_r.sr) && $stable(st_r.latch)))
      else $error("write with lane 0 off had an effect");

   a_other_read_zero: assert property (@(posedge pclk) disable iff (!presetn)
      (setup && !(is_status && !pwrite)) |=> (prdata == 32'h00000000))
      else $error("read data not zero outside a status read");

   a_status_upper_zero: assert property (@(posedge pclk) disable iff (!presetn)
      s_setup ##1 s_status_access |-> (prdata[31:1] == 31'h00000000))
      else $error("status read returned bits above bit 0");

   // Read data stands until the next setup so a slow master still sees it
   a_rdata_holds: assert property (@(posedge pclk) disable iff (!presetn)
      !setup |=> $stable(prdata))
      else $error("read data changed outside a setup cycle");

   a_mapped_no_err: assert property (@(posedge pclk) disable iff (!presetn)
      (setup && hit) |=> (pready && !pslverr))
      else $error("mapped register answered with an error");

   a_ready_idle: assert property (@(posedge pclk) disable iff (!presetn)
      !setup |=> !pready)
      else $error("ready raised without a setup cycle");

   // Reset defaults: 50 ohm, filter out, both registers on the same pattern
   a_reset_term_50: assert property (@(posedge pclk)
      $rose(presetn) |-> (!ch1_termination_sel && !ch2_termination_sel))
      else $error("reset did not select 50 ohm termination");

   a_reset_filter_out: assert property (@(posedge pclk)
      $rose(presetn) |-> (!ch1_lowpass_in && !ch2_lowpass_in))
      else $error("reset did not switch the filters out");

   a_reset_latch_pattern: assert property (@(posedge pclk)
      $rose(presetn) |-> (st_r.latch == AFCS_RESET_PATTERN))
      else $error("reset did not load the latch pattern");

   a_reset_sr_pattern: assert property (@(posedge pclk)
      $rose(presetn) |-> (st_r.sr == AFCS_RESET_PATTERN))
      else $error("reset did not load the shift register pattern");

endmodule
`default_nettype wire

//--- verification/afcs_testbench.sv
// Self-checking bench for the front-end configuration shifter, driven over APB.
// Assumes one wait-free access cycle per transfer and the package reset pattern.
`default_nettype none
module testbench;
   import afcs_pkg::*;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [11:0] A_ST = {AFCS_IDX_STATUS, 2'b00};
   localparam logic [11:0] A_SE = {AFCS_IDX_SERIAL, 2'b00};
   localparam logic [11:0] A_SB = {AFCS_IDX_STROBE, 2'b00};
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [3:0] pstrb = 4'hf;
   logic [31:0] prdata, rd;
   logic pready, pslverr, err;
   logic [17:0] outs;
   logic [55:0] sr_m, lat_m;
   // Channel 1 inputs, channel 2 inputs, then routed range with ch1 stages and ch2 20 dB stages inserted
   logic [55:0] masks [3] = '{56'h000010000002c0, 56'h00100000005800, 56'h000c6c00008400};
   int fail_count = 0;
   int n_compared = 0;
   int cyc = 0;
   // Stand-in for the relay settle time; the real wait is far beyond a bench run
   localparam int SETTLE_CYC = 40;

   afcs_shifter DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .ch1_single_input_en(outs[17]),
      .ch2_single_input_en(outs[16]), .ch1_diff_input_off(outs[15]),
      .ch2_diff_input_off(outs[14]), .ch1_termination_sel(outs[13]),
      .ch2_termination_sel(outs[12]), .ch1_lowpass_in(outs[11]), .ch2_lowpass_in(outs[10]),
      .ch1_atten_route(outs[9]), .ch2_atten_route(outs[8]),
      .ch1_input_20db_stage_off(outs[7]), .ch2_input_20db_stage_off(outs[6]),
      .ch1_post_stage_off(outs[5]), .ch2_post_stage_off(outs[4]),
      .ch1_internal_stage_off(outs[3]), .ch2_internal_stage_off(outs[2]),
      .ch1_internal14_stage_off(outs[1]), .ch2_internal14_stage_off(outs[0]));

   always #4 pclk = ~pclk;

   function automatic logic [17:0] pick(input logic [55:0] v);
      return {v[AFCS_B_CH1_SE], v[AFCS_B_CH2_SE], v[AFCS_B_CH1_DIFF], v[AFCS_B_CH2_DIFF],
         v[AFCS_B_CH1_TERM], v[AFCS_B_CH2_TERM], v[AFCS_B_CH1_LPF], v[AFCS_B_CH2_LPF],
         v[AFCS_B_CH1_ROUTE], v[AFCS_B_CH2_ROUTE], v[AFCS_B_CH1_IN20], v[AFCS_B_CH2_IN20],
         v[AFCS_B_CH1_POST], v[AFCS_B_CH2_POST], v[AFCS_B_CH1_INT6], v[AFCS_B_CH2_INT6],
         v[AFCS_B_CH1_INT14], v[AFCS_B_CH2_INT14]};
   endfunction

   task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fail_count++;
         $display("unexpected %s: expected %h, seen %h", name, exp, seen);
      end
   endtask

   task automatic stop_test();
      $display("compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   // Extra idle edge after release keeps each signal to one assignment per time step
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      // Only the bench timeout ends a wait for ready
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic rotate(input logic [55:0] want);
      for (int i = 55; i >= 0; i--) begin
         apb(1'b0, A_ST, 32'h0);
         check("status word", 64'(rd), 64'(sr_m[55]));
         apb(1'b1, A_SE, {31'h0, want[i]});
         sr_m = {sr_m[54:0], want[i]};
      end
      check("outputs before strobe", 64'(outs), 64'(pick(lat_m)));
   endtask

   task automatic strobe(input logic [7:0] code);
      apb(1'b1, A_SB, {24'h0, code});
      if (code === AFCS_STROBE_CODE)
         lat_m = sr_m;
      check("latched outputs", 64'(outs), 64'(pick(lat_m)));
      // No sampling is done while relays settle; the configuration must stand
      repeat (SETTLE_CYC) @(posedge pclk);
      check("outputs after settle", 64'(outs), 64'(pick(lat_m)));
   endtask

   // Refused accesses: error only when unmapped or misaligned, never an effect
   task automatic refused();
      apb(1'b1, A_ST, 32'h1);
      check("status write error", 64'(err), 64'h0);
      apb(1'b0, 12'h010, 32'h0);
      check("unmapped error", 64'(err), 64'h1);
      apb(1'b0, A_ST | 12'h001, 32'h0);
      check("misaligned error", 64'(err), 64'h1);
      apb(1'b0, A_SE, 32'h0);
      check("serial read data", 64'(rd), 64'h0);
      check("serial read error", 64'(err), 64'h0);
      pstrb <= 4'he;
      apb(1'b1, A_SE, 32'h1);
      pstrb <= 4'hf;
      apb(1'b0, A_ST, 32'h0);
      check("status after lane-off write", 64'(rd), 64'(sr_m[55]));
   endtask

   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         stop_test();
      end
   end

   initial begin
      sr_m = AFCS_RESET_PATTERN;
      lat_m = AFCS_RESET_PATTERN;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      check("reset outputs", 64'(outs), 64'(pick(lat_m)));
      refused();
      foreach (masks[k]) begin
         rotate(sr_m ^ masks[k]);
         strobe(8'h05);
         strobe(AFCS_STROBE_CODE);
      end
      // Mid-run reset must restore both the latch and the shift register
      presetn <= 1'b0;
      @(posedge pclk);
      presetn <= 1'b1;
      sr_m = AFCS_RESET_PATTERN;
      lat_m = AFCS_RESET_PATTERN;
      @(posedge pclk);
      check("outputs after reset", 64'(outs), 64'(pick(lat_m)));
      rotate(AFCS_RESET_PATTERN);
      stop_test();
   end
endmodule
`default_nettype wire
